// File: pcpc_top.v
// Port charging power control: upstream charger detection and downstream charging ports
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`include "pcpc_map.vh"

module pcpc_top (
    input  wire        clock_in,
    input  wire        rst_in,
    // Avalon-MM slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // Hub stage and clocking
    input  wire        charger_detect_stage_in,
    input  wire        wait_for_refclock_stage_in,
    input  wire        reference_clock_active_in,
    input  wire        osc_tick_in,
    input  wire        strap_window_in,
    input  wire        usb_cfg_valid_in,
    input  wire [4:1]  usb_cfg_charge_en_in,
    input  wire        otp_valid_in,
    input  wire [4:1]  otp_charge_en_in,
    // Upstream line classifier
    input  wire [2:0]  upstream_line_class_in,
    output reg         upstream_probe_out,
    output reg         detect_irq_out,
    // Downstream ports
    input  wire [4:1]  charge_enable_strap_in,
    input  wire [4:1]  overcurrent_sense_in,
    input  wire        host_connected_in,
    input  wire [4:1]  host_port_power_in,
    output reg  [4:1]  port_power_out,
    output reg  [1:0]  dcp_profile_out
);

// ----------------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------------
localparam [2:0] DS_IDLE   = 3'h0;
localparam [2:0] DS_PROBE  = 3'h1;
localparam [2:0] DS_SETTLE = 3'h2;
localparam [2:0] DS_DONE   = 3'h3;

reg  [4:0]  ctrl_ff;
reg  [4:1]  chg_en_ff;
reg  [2:0]  chg_type_ff;
reg  [2:0]  det_state_ff;
reg  [7:0]  settle_ff;
reg         stage_seen_ff;
reg  [3:0]  custom_ff;
reg  [1:0]  profile_ff;
reg  [15:0] ms_div_ff;
reg         ms_tick_ff;
reg  [4:1]  strap_ff;

wire [4:1]  oc_sync;
wire [4:1]  power_w;
wire [1:0]  role_w   [4:1];
wire [1:0]  tries_w  [4:1];
wire        ganged_oc = |oc_sync;
wire        det_step;
wire        enh_det   = ctrl_ff[`PCPC_CTRL_ENH_DET];
wire        cfg_done  = ctrl_ff[`PCPC_CTRL_CFG_DONE];

// Oscillator path lets detection run while the reference clock is dead
assign det_step = (ctrl_ff[`PCPC_CTRL_OSC_DET] && wait_for_refclock_stage_in)
                  ? osc_tick_in : reference_clock_active_in;

// ----------------------------------------------------------------------
// Over-current pin synchronisers
// ----------------------------------------------------------------------
genvar gi;
generate
    for (gi = 1; gi <= 4; gi = gi + 1) begin : g_port
        pcpc_sync u_sync (
            .clock_in  (clock_in),
            .rst_in    (rst_in),
            .pin_in    (overcurrent_sense_in[gi]),
            .level_out (oc_sync[gi])
        );
        pcpc_port u_port (
            .clock_in      (clock_in),
            .rst_in        (rst_in),
            .ms_tick_in    (ms_tick_ff),
            .cfg_done_in   (cfg_done),
            .charge_en_in  (chg_en_ff[gi]),
            .host_conn_in  (host_connected_in),
            .host_power_in (host_port_power_in[gi]),
            .oc_in         (oc_sync[gi]),
            .ganged_oc_in  (ganged_oc),
            .ganged_in     (ctrl_ff[`PCPC_CTRL_GANGED]),
            .power_out     (power_w[gi]),
            .role_out      (role_w[gi]),
            .tries_out     (tries_w[gi])
        );
    end
endgenerate

// ----------------------------------------------------------------------
// Millisecond enable divider
// ----------------------------------------------------------------------
always @(posedge clock_in) begin
    if (rst_in) begin
        ms_div_ff  <= 16'h0;
        ms_tick_ff <= 1'b0;
    end else if (ms_div_ff == `PCPC_MS_CYCLES - 1) begin
        ms_div_ff  <= 16'h0;
        ms_tick_ff <= 1'b1;
    end else begin
        ms_div_ff  <= ms_div_ff + 16'h1;
        ms_tick_ff <= 1'b0;
    end
end

// ----------------------------------------------------------------------
// Charging enable sources
// ----------------------------------------------------------------------
// Straps are plain levels sampled while the window is open
always @(posedge clock_in) begin
    if (rst_in) begin
        strap_ff  <= 4'h0;
    end else if (strap_window_in) begin
        strap_ff  <= charge_enable_strap_in;
    end
end

// Later sources override straps; all lock with configuration done
always @(posedge clock_in) begin
    if (rst_in) begin
        chg_en_ff <= 4'h0;
    end else if (!cfg_done) begin
        if (avs_write && !avs_waitrequest && avs_address == `PCPC_ADDR_CHG_EN) begin
            chg_en_ff <= avs_writedata[4:1];
        end else if (usb_cfg_valid_in) begin
            chg_en_ff <= usb_cfg_charge_en_in;
        end else if (otp_valid_in) begin
            chg_en_ff <= otp_charge_en_in;
        end else if (strap_window_in) begin
            chg_en_ff <= strap_ff;
        end
    end
end

// ----------------------------------------------------------------------
// Upstream charger detection
// ----------------------------------------------------------------------
// The upstream line class and the enhanced-detect bit decide the charger type
always @(posedge clock_in) begin
    if (rst_in) begin
        det_state_ff   <= DS_IDLE;
        settle_ff      <= 8'h0;
        stage_seen_ff  <= 1'b0;
        chg_type_ff    <= `PCPC_TYPE_NONE;
        upstream_probe_out <= 1'b0;
        detect_irq_out <= 1'b0;
    end else begin
        stage_seen_ff <= charger_detect_stage_in;
        case (det_state_ff)
        DS_IDLE: begin
            upstream_probe_out <= custom_ff[0];
            if (ctrl_ff[`PCPC_CTRL_DET_EN] && charger_detect_stage_in && !stage_seen_ff) begin
                det_state_ff <= DS_PROBE;
            end
        end
        DS_PROBE: begin
            upstream_probe_out <= 1'b1;
            settle_ff    <= 8'h0;
            det_state_ff <= DS_SETTLE;
        end
        DS_SETTLE: begin
            if (det_step) begin
                settle_ff <= settle_ff + 8'h1;
            end
            if (settle_ff == `PCPC_SETTLE_CYCLES) begin
                case (upstream_line_class_in)
                `PCPC_LINE_SHORTED:    chg_type_ff <= `PCPC_TYPE_DCP;
                `PCPC_LINE_REFLECT:    chg_type_ff <= enh_det ? `PCPC_TYPE_CDP
                                                              : `PCPC_TYPE_SDP;
                `PCPC_LINE_PULLDOWN:   chg_type_ff <= `PCPC_TYPE_SDP;
                `PCPC_LINE_PROP_LOW:   chg_type_ff <= `PCPC_TYPE_PROP_LOW;
                `PCPC_LINE_PROP_HIGH:  chg_type_ff <= `PCPC_TYPE_PROP_HIGH;
                `PCPC_LINE_PROP_SUPER: chg_type_ff <= `PCPC_TYPE_PROP_SUPER;
                default:               chg_type_ff <= `PCPC_TYPE_NONE;
                endcase
                upstream_probe_out <= 1'b0;
                det_state_ff <= DS_DONE;
            end
        end
        DS_DONE: begin
            detect_irq_out <= 1'b1;
            det_state_ff   <= DS_IDLE;
        end
        default: det_state_ff <= DS_IDLE;
        endcase
        // Set wins over the read-clear in the same cycle
        if (avs_read && !avs_waitrequest && avs_address == `PCPC_ADDR_STATUS
            && det_state_ff != DS_DONE) begin
            detect_irq_out <= 1'b0;
        end
    end
end

// ----------------------------------------------------------------------
// Avalon-MM slave: one wait cycle, then answer
// ----------------------------------------------------------------------
always @(posedge clock_in) begin
    if (rst_in) begin
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h0;
        ctrl_ff         <= `PCPC_CTRL_RESET;
        custom_ff       <= 4'h0;
        profile_ff      <= 2'h0;
    end else begin
        avs_waitrequest <= 1'b1;
        if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            if (avs_read) begin
                if (avs_address == `PCPC_ADDR_CTRL) begin
                    avs_readdata <= {27'h0, ctrl_ff};
                end else if (avs_address == `PCPC_ADDR_CHG_EN) begin
                    avs_readdata <= {27'h0, chg_en_ff, 1'b0};
                end else if (avs_address == `PCPC_ADDR_STATUS) begin
                    avs_readdata <= {28'h0, detect_irq_out, chg_type_ff};
                end else if (avs_address == `PCPC_ADDR_PORT_PWR) begin
                    avs_readdata <= {27'h0, power_w, 1'b0};
                end else if (avs_address == `PCPC_ADDR_CUSTOM) begin
                    avs_readdata <= {26'h0, profile_ff, custom_ff};
                end else if (avs_address == `PCPC_ADDR_ROLE) begin
                    avs_readdata <= {16'h0, tries_w[4], tries_w[3], tries_w[2], tries_w[1],
                                     role_w[4], role_w[3], role_w[2], role_w[1]};
                end else begin
                    avs_readdata <= 32'h0;
                end
            end else if (avs_address == `PCPC_ADDR_CTRL) begin
                // Configuration done sticks; charging enables stay frozen afterwards, roles still follow the host connection
                ctrl_ff <= {ctrl_ff[4] | avs_writedata[4], avs_writedata[3:0]};
            end else if (avs_address == `PCPC_ADDR_CUSTOM) begin
                // Accepted in every stage; software keeps to the safe stages
                custom_ff  <= avs_writedata[3:0];
                profile_ff <= avs_writedata[5:4];
            end
        end
    end
end

// ----------------------------------------------------------------------
// Port pins
// ----------------------------------------------------------------------
always @(posedge clock_in) begin
    if (rst_in) begin
        port_power_out  <= 4'h0;
        dcp_profile_out <= 2'h0;
    end else begin
        port_power_out  <= power_w;
        dcp_profile_out <= profile_ff;
    end
end

endmodule // pcpc_top

// File: pcpc_map.vh
// Register offsets, field layouts, reset values and timing counts for port charging control
`ifndef PCPC_MAP_VH
`define PCPC_MAP_VH

// ----------------------------------------------------------------------
// Register word addresses (one step per 32-bit register)
// ----------------------------------------------------------------------
`define PCPC_ADDR_CTRL        4'h0
`define PCPC_ADDR_CHG_EN      4'h1
`define PCPC_ADDR_STATUS      4'h2
`define PCPC_ADDR_PORT_PWR    4'h3
`define PCPC_ADDR_CUSTOM      4'h4
`define PCPC_ADDR_ROLE        4'h5

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define PCPC_CTRL_DET_EN      0
`define PCPC_CTRL_ENH_DET     1
`define PCPC_CTRL_OSC_DET     2
`define PCPC_CTRL_GANGED      3
`define PCPC_CTRL_CFG_DONE    4
`define PCPC_CTRL_RESET       5'h01

// ----------------------------------------------------------------------
// Charger type codes
// ----------------------------------------------------------------------
`define PCPC_TYPE_NONE        3'h0
`define PCPC_TYPE_DCP         3'h1
`define PCPC_TYPE_CDP         3'h2
`define PCPC_TYPE_SDP         3'h3
`define PCPC_TYPE_PROP_LOW    3'h4
`define PCPC_TYPE_PROP_HIGH   3'h5
`define PCPC_TYPE_PROP_SUPER  3'h6

// ----------------------------------------------------------------------
// Line state classes from the analog front end
// ----------------------------------------------------------------------
`define PCPC_LINE_SHORTED     3'h1
`define PCPC_LINE_REFLECT     3'h2
`define PCPC_LINE_PULLDOWN    3'h3
`define PCPC_LINE_PROP_LOW    3'h4
`define PCPC_LINE_PROP_HIGH   3'h5
`define PCPC_LINE_PROP_SUPER  3'h6

// ----------------------------------------------------------------------
// Port roles
// ----------------------------------------------------------------------
`define PCPC_ROLE_SDP         2'h0
`define PCPC_ROLE_CDP         2'h1
`define PCPC_ROLE_DCP         2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PCPC_CLK_HZ           50000000
`define PCPC_MS_CYCLES        (`PCPC_CLK_HZ / 1000)
`define PCPC_SHORT_OFF_MS     1000
`define PCPC_LONG_OFF_MS      10000
`define PCPC_SHORT_TRIES      2'h3
`define PCPC_SETTLE_CYCLES    8'h20

`endif

// File: pcpc_sync.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps

module pcpc_sync (
    input  wire clock_in,
    input  wire rst_in,
    input  wire pin_in,
    output reg  level_out
);

reg meta_ff;
reg s2_ff;
reg s3_ff;

// ----------------------------------------------------------------------
// Level counts only once stages two and three agree
// ----------------------------------------------------------------------
always @(posedge clock_in) begin
    if (rst_in) begin
        meta_ff   <= 1'b0;
        s2_ff     <= 1'b0;
        s3_ff     <= 1'b0;
        level_out <= 1'b0;
    end else begin
        meta_ff <= pin_in;
        s2_ff   <= meta_ff;
        s3_ff   <= s2_ff;
        if (s2_ff == s3_ff) begin
            level_out <= s3_ff;
        end
    end
end

endmodule // pcpc_sync

// File: pcpc_port.v
// Per-port power and over-current retry control
`timescale 1ns/1ps
`include "pcpc_map.vh"

module pcpc_port #(
    parameter [31:0] MS_CYCLES = `PCPC_MS_CYCLES
) (
    input  wire       clock_in,
    input  wire       rst_in,
    input  wire       ms_tick_in,
    input  wire       cfg_done_in,
    input  wire       charge_en_in,
    input  wire       host_conn_in,
    input  wire       host_power_in,
    input  wire       oc_in,
    input  wire       ganged_oc_in,
    input  wire       ganged_in,
    output reg        power_out,
    output reg  [1:0] role_out,
    output reg  [1:0] tries_out
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_ON   = 2'h1;
localparam [1:0] ST_OFF  = 2'h2;

reg [1:0]  state_ff;
reg [13:0] ms_cnt_ff;
reg        locked_ff;
reg        charge_ff;

wire fault = ganged_in ? ganged_oc_in : oc_in;
wire [13:0] off_ms = (tries_out == `PCPC_SHORT_TRIES) ? 14'd`PCPC_LONG_OFF_MS
                                                      : 14'd`PCPC_SHORT_OFF_MS;

always @(posedge clock_in) begin
    if (rst_in) begin
        state_ff  <= ST_IDLE;
        ms_cnt_ff <= 14'h0;
        locked_ff <= 1'b0;
        charge_ff <= 1'b0;
        power_out <= 1'b0;
        role_out  <= `PCPC_ROLE_SDP;
        tries_out <= 2'h0;
    end else begin
        // Charging enable frozen once configuration closes
        if (cfg_done_in && !locked_ff) begin
            locked_ff <= 1'b1;
            charge_ff <= charge_en_in;
        end
        if (!locked_ff) begin
            role_out <= `PCPC_ROLE_SDP;
        end else if (charge_ff) begin
            role_out <= host_conn_in ? `PCPC_ROLE_CDP : `PCPC_ROLE_DCP;
        end else begin
            role_out <= `PCPC_ROLE_SDP;
        end
        case (state_ff)
        ST_IDLE: begin
            power_out <= 1'b0;
            // Standard ports go live too; their power is the host's call
            if (locked_ff) begin
                state_ff <= ST_ON;
            end
        end
        ST_ON: begin
            if (role_out != `PCPC_ROLE_DCP) begin
                // Host owns power, a local fault only gates it; event not recorded
                power_out <= host_power_in && !fault;
                tries_out <= 2'h0;
            end else if (fault) begin
                power_out <= 1'b0;
                ms_cnt_ff <= 14'h0;
                state_ff  <= ST_OFF;
            end else begin
                power_out <= 1'b1;
                tries_out <= 2'h0;
            end
        end
        ST_OFF: begin
            power_out <= 1'b0;
            if (ms_tick_in) begin
                if (ms_cnt_ff + 14'h1 >= off_ms) begin
                    // Retry forever; never a permanent disable
                    if (tries_out != `PCPC_SHORT_TRIES) begin
                        tries_out <= tries_out + 2'h1;
                    end
                    power_out <= 1'b1;
                    state_ff  <= ST_ON;
                end else begin
                    ms_cnt_ff <= ms_cnt_ff + 14'h1;
                end
            end
        end
        default: state_ff <= ST_IDLE;
        endcase
    end
end

endmodule // pcpc_port

// File: pcpc_checker.sv
// Assertion checker for port charging power control
`timescale 1ns/1ps
`include "pcpc_map.vh"
module pcpc_checker (
    input wire        clock_in,
    input wire        rst_in,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire        charger_detect_stage_in,
    input wire        upstream_probe_out,
    input wire        detect_irq_out,
    input wire [4:1]  host_port_power_in,
    input wire [4:1]  overcurrent_sense_in,
    input wire [4:1]  port_power_out,
    input wire [1:0]  dcp_profile_out
);
    // ----------
    // Helpers
    // ----------
    reg  [1:0] prof_ff;
    reg  [3:0] oc_ff;
    wire       take = avs_waitrequest && (avs_read || avs_write);
    wire       st_rd = avs_read && avs_address == `PCPC_ADDR_STATUS;
    wire       oc1 = overcurrent_sense_in[1] && !host_port_power_in[1];
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (rst_in);
    always @(posedge clock_in) begin
        if (take && avs_write && avs_address == `PCPC_ADDR_CUSTOM)
            prof_ff <= avs_writedata[5:4];
        // Saturate so a long fault cannot wrap back to zero
        oc_ff <= !oc1 ? 4'h0 : (oc_ff == 4'hf) ? oc_ff : oc_ff + 4'h1;
    end
    // ----------
    // Assertions
    // ----------
    AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low longer than one cycle");
    AST_ANSWER: assert property (take |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    AST_RDATA_HOLD: assert property (!(take && avs_read) |=> $stable(avs_readdata))
        else $error("read data changed without a read");
    AST_UNMAPPED: assert property (take && avs_read && avs_address > 4'h5
        |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    AST_IRQ_HOLD: assert property (detect_irq_out && !st_rd |=> detect_irq_out)
        else $error("interrupt dropped without status read");
    AST_IRQ_CLEAR: assert property ($fell(detect_irq_out) |-> $past(st_rd))
        else $error("interrupt cleared by other access");
    AST_IRQ_SOURCE: assert property ($rose(detect_irq_out)
        |-> $past(upstream_probe_out) || $past(upstream_probe_out, 2))
        else $error("interrupt without detection");
    AST_PROBE_SETTLE: assert property ($rose(upstream_probe_out) && charger_detect_stage_in
        |=> upstream_probe_out [*8])
        else $error("probe shorter than settle time");
    AST_OC_CUT: assert property (oc_ff == 4'hc |-> !port_power_out[1])
        else $error("port power kept during fault");
    AST_OC_OFF: assert property ($fell(port_power_out[1]) && !host_port_power_in[1]
        && !$past(host_port_power_in[1]) |=> !port_power_out[1] [*8])
        else $error("faulted port re-enabled too soon");
    AST_PROFILE: assert property (take && avs_write && avs_address == `PCPC_ADDR_CUSTOM
        |-> ##[1:4] dcp_profile_out == prof_ff)
        else $error("profile output not updated");
    COV_IRQ: cover property ($rose(detect_irq_out));
    COV_OC: cover property ($fell(port_power_out[2]));
    COV_EN_WR: cover property (avs_write && !avs_waitrequest && avs_address == `PCPC_ADDR_CHG_EN);
endmodule // pcpc_checker

bind pcpc_top pcpc_checker chk_i (
    .clock_in, .rst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .charger_detect_stage_in, .upstream_probe_out,
    .detect_irq_out, .host_port_power_in, .overcurrent_sense_in, .port_power_out,
    .dcp_profile_out
);

// File: pcpc_charger_model.sv
// Attached charger answering the upstream line probe
`timescale 1ns/1ps
module pcpc_charger_model (
    input  wire       clock_in,
    input  wire       probe_in,
    input  wire       slow_in,
    input  wire [2:0] line_sel_in,
    output reg  [2:0] line_class_out
);
    reg [2:0] wait_ff = 3'h0;
    reg [1:0] hold_ff = 2'h0;
    initial line_class_out = 3'h0;
    always @(posedge clock_in) begin
        if (probe_in) begin
            hold_ff <= 2'h2;
            if (slow_in && wait_ff != 3'h4) begin
                // A slow charger shows an unsettled class first
                wait_ff <= wait_ff + 3'h1;
                line_class_out <= line_class_out + 3'h1;
            end else begin
                line_class_out <= line_sel_in;
            end
        end else if (hold_ff != 2'h0) begin
            hold_ff <= hold_ff - 2'h1;
            wait_ff <= 3'h0;
        end else begin
            // Released lines toggle between the last class and its inverse
            line_class_out <= ~line_class_out;
        end
    end
endmodule // pcpc_charger_model

// File: tb.sv
// Self-checking testbench for port charging power control
`timescale 1ns/1ps
`include "pcpc_map.vh"
module tb;
    logic        clock_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        charger_detect_stage_in = 1'b0;
    logic        wait_for_refclock_stage_in = 1'b0;
    logic        reference_clock_active_in = 1'b1;
    logic        osc_tick_in = 1'b0;
    logic        strap_window_in = 1'b1;
    logic        usb_cfg_valid_in = 1'b0;
    logic [4:1]  usb_cfg_charge_en_in = 4'h8;
    logic        otp_valid_in = 1'b0;
    logic [4:1]  otp_charge_en_in = 4'h6;
    logic [2:0]  upstream_line_class_in;
    logic        upstream_probe_out;
    logic        detect_irq_out;
    logic [4:1]  charge_enable_strap_in = 4'h5;
    logic [4:1]  overcurrent_sense_in = 4'h0;
    logic        host_connected_in = 1'b0;
    logic [4:1]  host_port_power_in = 4'h0;
    logic [4:1]  port_power_out;
    logic [1:0]  dcp_profile_out;
    logic [2:0]  line_sel = 3'h0;
    logic        slow = 1'b0;
    logic [31:0] rd;
    int          error_cnt = 0;
    int          checks = 0;
    // Rows: {enhanced detect, line class, expected type}
    logic [6:0]  rows [9] = '{7'h09, 7'h52, 7'h13, 7'h1b, 7'h5b, 7'h24, 7'h2d, 7'h36, 7'h38};
    always #10 clock_in = ~clock_in;
    always @(posedge clock_in) osc_tick_in <= ~osc_tick_in;
    pcpc_top dut (.clock_in, .rst_in, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .charger_detect_stage_in, .wait_for_refclock_stage_in,
        .reference_clock_active_in, .osc_tick_in, .strap_window_in, .usb_cfg_valid_in,
        .usb_cfg_charge_en_in, .otp_valid_in, .otp_charge_en_in, .upstream_line_class_in,
        .upstream_probe_out, .detect_irq_out, .charge_enable_strap_in, .overcurrent_sense_in,
        .host_connected_in, .host_port_power_in, .port_power_out, .dcp_profile_out);
    pcpc_charger_model partner (.clock_in, .probe_in(upstream_probe_out), .slow_in(slow),
        .line_sel_in(line_sel), .line_class_out(upstream_line_class_in));
    // ----------
    // Tasks
    // ----------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d = 32'h0);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do begin
            @(posedge clock_in);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        chk("bus_answer", 32'h0, 32'(avs_waitrequest));
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic detect(input logic [2:0] line, input logic [2:0] exp);
        int n;
        n = 0;
        line_sel <= line;
        charger_detect_stage_in <= 1'b1;
        do begin
            @(posedge clock_in);
            n++;
        end while (detect_irq_out !== 1'b1 && n < 3000);
        chk("detect_irq", 32'h1, 32'(detect_irq_out));
        charger_detect_stage_in <= 1'b0;
        bus(1'b0, `PCPC_ADDR_STATUS);
        chk("charger_type", 32'(exp), 32'(rd[2:0]));
        chk("irq_release", 32'h0, 32'(detect_irq_out));
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ----------
    // Sequence
    // ----------
    initial begin
        tick(6);
        rst_in <= 1'b0;
        tick(1);
        bus(1'b0, `PCPC_ADDR_CTRL);
        chk("ctrl_reset", 32'h1, rd);
        bus(1'b1, 4'h9, 32'hffff);
        bus(1'b0, 4'h9);
        chk("unmapped", 32'h0, rd);
        strap_window_in <= 1'b0;
        bus(1'b0, `PCPC_ADDR_CHG_EN);
        chk("strap_en", 32'ha, rd);
        usb_cfg_valid_in <= 1'b1;
        tick(1);
        usb_cfg_valid_in <= 1'b0;
        bus(1'b0, `PCPC_ADDR_CHG_EN);
        chk("usb_en", 32'h10, rd);
        otp_valid_in <= 1'b1;
        tick(1);
        otp_valid_in <= 1'b0;
        bus(1'b0, `PCPC_ADDR_CHG_EN);
        chk("otp_en", 32'hc, rd);
        bus(1'b1, `PCPC_ADDR_CHG_EN, 32'h6);
        bus(1'b0, `PCPC_ADDR_CHG_EN);
        chk("serial_en", 32'h6, rd);
        for (int i = 0; i < 9; i++) begin
            slow <= i[0];
            bus(1'b1, `PCPC_ADDR_CTRL, {30'h0, rows[i][6], 1'b1});
            detect(rows[i][5:3], rows[i][2:0]);
        end
        // Detection on the internal oscillator with the reference clock stopped
        reference_clock_active_in <= 1'b0;
        wait_for_refclock_stage_in <= 1'b1;
        bus(1'b1, `PCPC_ADDR_CTRL, 32'h5);
        detect(`PCPC_LINE_SHORTED, `PCPC_TYPE_DCP);
        reference_clock_active_in <= 1'b1;
        wait_for_refclock_stage_in <= 1'b0;
        bus(1'b1, `PCPC_ADDR_CUSTOM, 32'h21);
        tick(3);
        chk("custom_probe", 32'h1, 32'(upstream_probe_out));
        chk("dcp_profile", 32'h2, 32'(dcp_profile_out));
        bus(1'b1, `PCPC_ADDR_CUSTOM, 32'h20);
        host_port_power_in <= 4'h4;
        bus(1'b1, `PCPC_ADDR_CTRL, 32'h11);
        tick(10);
        chk("port_power", 32'h7, 32'(port_power_out));
        bus(1'b0, `PCPC_ADDR_PORT_PWR);
        chk("port_pwr_reg", 32'h6, rd & 32'h6);
        bus(1'b0, `PCPC_ADDR_ROLE);
        chk("roles", 32'ha, rd & 32'hff);
        bus(1'b1, `PCPC_ADDR_CHG_EN, 32'h1e);
        bus(1'b0, `PCPC_ADDR_CHG_EN);
        chk("en_locked", 32'h6, rd);
        overcurrent_sense_in <= 4'h1;
        tick(12);
        chk("oc_indiv", 32'h6, 32'(port_power_out));
        overcurrent_sense_in <= 4'h0;
        tick(40);
        chk("oc_off", 32'h0, 32'(port_power_out[1]));
        bus(1'b1, `PCPC_ADDR_CTRL, 32'h19);
        overcurrent_sense_in <= 4'h4;
        tick(12);
        chk("oc_ganged", 32'h0, 32'(port_power_out[2]));
        overcurrent_sense_in <= 4'h0;
        // Second reset: one charging port behind a connected host
        rst_in <= 1'b1;
        strap_window_in <= 1'b1;
        charge_enable_strap_in <= 4'h1;
        host_connected_in <= 1'b1;
        host_port_power_in <= 4'h0;
        tick(6);
        rst_in <= 1'b0;
        tick(2);
        strap_window_in <= 1'b0;
        bus(1'b1, `PCPC_ADDR_CTRL, 32'h11);
        bus(1'b0, `PCPC_ADDR_ROLE);
        chk("role_cdp", 32'h1, rd & 32'hff);
        host_port_power_in <= 4'h1;
        tick(8);
        chk("cdp_power", 32'h1, 32'(port_power_out));
        summarize();
    end
    initial begin
        tick(20000);
        error_cnt++;
        $display("mismatch watchdog expected %s seen %s", "done", "timeout");
        summarize();
    end
endmodule // tb
